// ---- design/tap_emulation_scan_port.sv ----
/*
 * tap controller, instruction, id, bypass and emulation registers,
 * halt output, full scan enable, reset indication and boot strap capture.
 * assumes all pins are asynchronous to sys_clk; test clock is much slower.
 */
`timescale 1ns/1ps
module tap_emulation_scan_port
(
    // system
    input wire logic sys_clk,
    input wire logic resetn,
    // test pins
    input wire logic test_port_clock,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    // scan and halt
    input wire logic scan_mode_in,
    output logic full_scan_enable,
    input wire logic halt_strap_in,
    output logic dsp_halt_out,
    output logic dsp_halt_oe,
    output logic boot_strap,
    output logic reset_indication_out
);
    logic [1:0] tck_sync_reg, tms_sync_reg, tdi_sync_reg, smo_sync_reg, strap_sync_reg;
    logic tck_last_reg;
    logic rise, fall;
    tap_port_pkg::tap_state_t state_reg;
    logic [3:0] ir_reg, ir_sh_reg;
    logic [31:0] dr_sh_reg;
    logic [7:0] emu_reg;
    logic [3:0] rcnt_reg;

    // two-stage synchronisers; trst stays asynchronous by design
    // test clock stages reset to its idle high level, so release shows no false edge
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tck_sync_reg <= 2'h3;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= 2'h3;
            smo_sync_reg <= 2'h0;
            strap_sync_reg <= 2'h0;
            tck_last_reg <= 1'b1;
        end
        else
        begin
            tck_sync_reg <= {tck_sync_reg[0], test_port_clock}; // [RL2]
            strap_sync_reg <= {strap_sync_reg[0], halt_strap_in};
            tms_sync_reg <= {tms_sync_reg[0], tms};
            tdi_sync_reg <= {tdi_sync_reg[0], tdi};
            smo_sync_reg <= {smo_sync_reg[0], scan_mode_in};
            tck_last_reg <= tck_sync_reg[1];
        end
    end
    assign rise = tck_sync_reg[1] & ~tck_last_reg; // [RL13]
    assign fall = ~tck_sync_reg[1] & tck_last_reg;

    // tap state machine, stepped on test clock rise by mode select
    always_ff @(posedge sys_clk or negedge trst_n or negedge resetn)
    begin
        if (!trst_n || !resetn)
            state_reg <= tap_port_pkg::TEST_LOGIC_RESET; // [RL7]
        else if (rise)
        begin
            case (state_reg) // [RL1] [RL3]
                tap_port_pkg::TEST_LOGIC_RESET: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::TEST_LOGIC_RESET : tap_port_pkg::RUN_TEST_IDLE;
                tap_port_pkg::RUN_TEST_IDLE: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::SELECT_DR : tap_port_pkg::RUN_TEST_IDLE;
                tap_port_pkg::SELECT_DR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::SELECT_IR : tap_port_pkg::CAPTURE_DR;
                tap_port_pkg::CAPTURE_DR, tap_port_pkg::SHIFT_DR: state_reg <=
                    tms_sync_reg[1] ? tap_port_pkg::EXIT1_DR : tap_port_pkg::SHIFT_DR;
                tap_port_pkg::EXIT1_DR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::UPDATE_DR : tap_port_pkg::PAUSE_DR;
                tap_port_pkg::PAUSE_DR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::EXIT2_DR : tap_port_pkg::PAUSE_DR;
                tap_port_pkg::EXIT2_DR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::UPDATE_DR : tap_port_pkg::SHIFT_DR;
                tap_port_pkg::SELECT_IR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::TEST_LOGIC_RESET : tap_port_pkg::CAPTURE_IR;
                tap_port_pkg::CAPTURE_IR, tap_port_pkg::SHIFT_IR: state_reg <=
                    tms_sync_reg[1] ? tap_port_pkg::EXIT1_IR : tap_port_pkg::SHIFT_IR;
                tap_port_pkg::EXIT1_IR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::UPDATE_IR : tap_port_pkg::PAUSE_IR;
                tap_port_pkg::PAUSE_IR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::EXIT2_IR : tap_port_pkg::PAUSE_IR;
                tap_port_pkg::EXIT2_IR: state_reg <= tms_sync_reg[1] ?
                    tap_port_pkg::UPDATE_IR : tap_port_pkg::SHIFT_IR;
                tap_port_pkg::UPDATE_DR, tap_port_pkg::UPDATE_IR: state_reg <=
                    tms_sync_reg[1] ? tap_port_pkg::SELECT_DR : tap_port_pkg::RUN_TEST_IDLE;
                default: state_reg <= tap_port_pkg::TEST_LOGIC_RESET;
            endcase
        end
    end

    // instruction register; id code is the default after tap reset
    always_ff @(posedge sys_clk or negedge trst_n or negedge resetn)
    begin
        if (!trst_n || !resetn)
        begin
            ir_reg <= tap_port_pkg::IR_IDCODE;
            ir_sh_reg <= 4'h0;
        end
        else if (rise)
        begin
            if (state_reg == tap_port_pkg::TEST_LOGIC_RESET)
                ir_reg <= tap_port_pkg::IR_IDCODE;
            else if (state_reg == tap_port_pkg::CAPTURE_IR)
                ir_sh_reg <= tap_port_pkg::IR_CAPTURE;
            else if (state_reg == tap_port_pkg::SHIFT_IR)
                ir_sh_reg <= {tdi_sync_reg[1], ir_sh_reg[3:1]}; // [RL4]
            else if (state_reg == tap_port_pkg::UPDATE_IR)
                ir_reg <= ir_sh_reg;
        end
    end

    // data shift path shared by id, bypass and emulation registers
    always_ff @(posedge sys_clk or negedge trst_n or negedge resetn)
    begin
        if (!trst_n || !resetn)
        begin
            dr_sh_reg <= 32'h0000_0000;
            emu_reg <= 8'h00;
        end
        else if (rise)
        begin
            if (state_reg == tap_port_pkg::CAPTURE_DR)
            begin
                case (ir_reg)
                    tap_port_pkg::IR_IDCODE: dr_sh_reg <= tap_port_pkg::ID_VALUE;
                    tap_port_pkg::IR_EMU: dr_sh_reg <= {24'h00_0000, emu_reg};
                    default: dr_sh_reg <= 32'h0000_0000;
                endcase
            end
            else if (state_reg == tap_port_pkg::SHIFT_DR)
            begin
                // emulation data shares the serial pins and test clock
                case (ir_reg) // [RL4]
                    tap_port_pkg::IR_IDCODE: dr_sh_reg <= {tdi_sync_reg[1], dr_sh_reg[31:1]};
                    tap_port_pkg::IR_EMU: dr_sh_reg <=
                        {24'h00_0000, tdi_sync_reg[1], dr_sh_reg[7:1]};
                    default: dr_sh_reg <= {31'h0000_0000, tdi_sync_reg[1]};
                endcase
            end
            else if (state_reg == tap_port_pkg::UPDATE_DR && ir_reg == tap_port_pkg::IR_EMU)
                emu_reg <= dr_sh_reg[7:0];
        end
    end

    // data output changes on the falling test clock edge only
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo_oe <= (state_reg == tap_port_pkg::SHIFT_DR) ||
                      (state_reg == tap_port_pkg::SHIFT_IR); // [RL6]
            tdo <= (state_reg == tap_port_pkg::SHIFT_IR) ? ir_sh_reg[0] : dr_sh_reg[0]; // [RL13]
        end
    end

    // reset indication stretch and strap capture while it is high
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rcnt_reg <= 4'h0;
            reset_indication_out <= 1'b1;
            boot_strap <= 1'b0;
        end
        else
        begin
            if (rcnt_reg != 4'(tap_port_pkg::RESET_INDICATION_OUT_CYC))
                rcnt_reg <= rcnt_reg + 4'h1;
            reset_indication_out <= (rcnt_reg != 4'(tap_port_pkg::RESET_INDICATION_OUT_CYC));
            if (reset_indication_out)
                boot_strap <= strap_sync_reg[1]; // [RL12]
        end
    end

    // halt pin is released while straps are sampled, then shows emu stop
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dsp_halt_out <= 1'b0;
            dsp_halt_oe <= 1'b0;
            full_scan_enable <= 1'b0;
        end
        else
        begin
            dsp_halt_oe <= ~reset_indication_out;
            dsp_halt_out <= ~reset_indication_out & emu_reg[tap_port_pkg::EMU_STOP_BIT]; // [RL8]
            // normal use keeps scan mode low, so data input stays test data
            full_scan_enable <= smo_sync_reg[1] & tdi_sync_reg[1]; // [RL9] [RL10]
        end
    end

    AST_SCAN_NEEDS_MODE: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL9]
        full_scan_enable |-> $past(smo_sync_reg[1])) else $error("scan without mode");
    AST_TRST_RESET: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL7]
        !trst_n |-> ##1 state_reg == tap_port_pkg::TEST_LOGIC_RESET)
        else $error("trst missed");
    AST_TDO_FALL: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL13]
        !fall |=> $stable(tdo)) else $error("tdo moved off fall");
    AST_HALT: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL8]
        dsp_halt_out |-> $past(emu_reg[tap_port_pkg::EMU_STOP_BIT]))
        else $error("halt without stop");
    AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL12]
        !$past(reset_indication_out) |-> $stable(boot_strap)) else $error("strap moved");
    AST_TDO_OE: assert property (@(posedge sys_clk) disable iff (!resetn || !trst_n) // [RL6]
        $rose(tdo_oe) |-> $past(state_reg == tap_port_pkg::SHIFT_DR ||
        state_reg == tap_port_pkg::SHIFT_IR)) else $error("oe outside shift");
    AST_TLR_STAY: assert property (@(posedge sys_clk) disable iff (!resetn || !trst_n) // [RL3]
        rise && tms_sync_reg[1] && state_reg == tap_port_pkg::TEST_LOGIC_RESET |=>
        state_reg == tap_port_pkg::TEST_LOGIC_RESET) else $error("tlr left");
    AST_IR_TLR: assert property (@(posedge sys_clk) disable iff (!resetn || !trst_n) // [RL1]
        rise && state_reg == tap_port_pkg::TEST_LOGIC_RESET |=> ir_reg ==
        tap_port_pkg::IR_IDCODE) else $error("ir not reset");

    // stop bit taken into the emulation register reaches the halt pin two edges later
    sequence emu_stop_load_s;
        rise && state_reg == tap_port_pkg::UPDATE_DR && ir_reg == tap_port_pkg::IR_EMU &&
            dr_sh_reg[tap_port_pkg::EMU_STOP_BIT] && !reset_indication_out;
    endsequence
    AST_HALT_STOP: assert property (@(posedge sys_clk) disable iff (!resetn || !trst_n) // [RL8]
        emu_stop_load_s |=> ##1 dsp_halt_out) else $error("halt missed stop");

    // a falling test clock seen in a shift state must turn the data output on
    sequence shift_fall_s;
        fall && (state_reg == tap_port_pkg::SHIFT_DR || state_reg == tap_port_pkg::SHIFT_IR);
    endsequence
    AST_OE_SHIFT: assert property (@(posedge sys_clk) disable iff (!resetn || !trst_n) // [RL6]
        shift_fall_s |=> tdo_oe) else $error("oe missing in shift");
endmodule

// ---- pkg/tap_port_pkg.sv ----
/*
 * constants for the test access port block: tap states, instruction codes,
 * register lengths and the emulation stop bit.
 * assumes the test clock is sampled by sys_clk, far slower than sys_clk.
 */
// What this block does
// RL1 - standard boundary-scan tap state machine and registers
// RL2 - tap and emulation timed by test clock
// RL3 - master steps tap states with mode select
// RL4 - shift states take bits from data input
// RL5 - board never holds data input low
// RL6 - shift states drive bits on data output
// RL7 - test reset resets tap asynchronously
// RL8 - halt output active while dsp stop issued
// RL9 - full scan only when mode and enable
// RL10 - scan mode reinterprets data input as enable
// RL11 - scan mode tied low in normal operation
// RL12 - strap sampled during reset, until indication drops
// RL13 - output on falling edge, inputs on rising
package tap_port_pkg;
    typedef enum logic [3:0]
    {
        TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
        PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
        PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;
    localparam int IR_LEN = 4;
    localparam int ID_LEN = 32;
    localparam int EMU_LEN = 8;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_EMU = 4'h8;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    // value arbitrary, not a real maker code
    localparam logic [31:0] ID_VALUE = 32'h0000_0001;
    localparam int EMU_STOP_BIT = 0;
    localparam int RESET_INDICATION_OUT_NS = 1000;
    localparam int CLK_NS = 100;
    localparam int RESET_INDICATION_OUT_CYC = (RESET_INDICATION_OUT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// ---- tb/test_master_model.sv ----
/*
 * behavioural test master: makes the test clock, drives mode select, data in
 * and test reset. assumes every task is entered right after a sys_clk edge.
 */
`timescale 1ns/1ps
module test_master_model
(
    // system
    input wire logic sys_clk,
    // test pins
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    // data in idles high, test clock stands still between frames
    initial
    begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // one 800 ns period; tdo taken at the end of the high phase, long after the fall update
    task automatic step(input logic m, input logic d, output logic q);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge sys_clk);
        tck <= 1'b1;
        repeat (4) @(posedge sys_clk);
        q = tdo;
    endtask
    // mode select pattern, lsb first, data in held high
    task automatic walk(input logic [7:0] pat, input int n);
        logic q;
        for (int i = 0; i < n; i++)
        begin
            step(pat[i], 1'b1, q);
        end
    endtask
    // shifts n bits lsb first; the last one leaves the shift state
    task automatic shift(input logic [31:0] din, input int n, output logic [31:0] dout);
        logic q;
        dout = 32'h0000_0000;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
    endtask
    task automatic set_tdi(input logic d);
        tdi <= d;
    endtask
    // asynchronous tap reset with the test clock standing still
    task automatic pulse_trst();
        trst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        trst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// ---- tb/tb.sv ----
/*
 * bench for the test port: reset, id, emulation halt, test reset, bypass, scan.
 * assumes the test master model drives the test pins.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); end end
module tb;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic scan_mode_in = 1'b0;
    logic halt_strap_in = 1'b1;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, fse, halt, halt_oe, boot, rind;
    logic [31:0] d;
    int err_total = 0;
    int compares = 0;
    always #50 sys_clk = ~sys_clk;
    // a released data output reads as its pull-up level at the master
    test_master_model i_master (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo_oe ? tdo : 1'b1));
    tap_emulation_scan_port i_dut (.sys_clk(sys_clk), .resetn(resetn),
        .test_port_clock(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe(tdo_oe), .scan_mode_in(scan_mode_in), .full_scan_enable(fse),
        .halt_strap_in(halt_strap_in), .dsp_halt_out(halt), .dsp_halt_oe(halt_oe),
        .boot_strap(boot), .reset_indication_out(rind));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // bounded wait on the halt output; running out ends the run
    task automatic wait_halt(input logic e);
        int n;
        n = 0;
        while (halt !== e && n < 20)
        begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("halt", e, halt)
        if (halt !== e) report_and_stop();
    endtask
    // strap must be the level seen before the indication drops, not the later one
    task automatic chk_reset();
        int n;
        n = 0;
        repeat (16) @(posedge sys_clk);
        `CHK("rind", 1'b1, rind)
        `CHK("halt_oe", 1'b0, halt_oe)
        resetn <= 1'b1;
        while (rind !== 1'b0 && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        halt_strap_in <= 1'b0;
        if (n == 40)
        begin
            err_total++;
            report_and_stop();
        end
        repeat (3) @(posedge sys_clk);
        `CHK("rind_min", 1'b1, n >= tap_port_pkg::RESET_INDICATION_OUT_CYC - 1)
        `CHK("rind_max", 1'b1, n <= tap_port_pkg::RESET_INDICATION_OUT_CYC + 3)
        `CHK("boot", 1'b1, boot)
        `CHK("halt_oe", 1'b1, halt_oe)
        `CHK("halt", 1'b0, halt)
    endtask
    task automatic chk_id();
        i_master.walk(8'b0001_1111, 6);
        i_master.walk(8'b0000_0001, 3);
        i_master.shift(32'hffff_ffff, 32, d);
        `CHK("id", tap_port_pkg::ID_VALUE, d)
        i_master.walk(8'b0000_0001, 2);
        `CHK("tdo_oe", 1'b0, tdo_oe)
    endtask
    // load the emulation instruction, then set the stop bit
    task automatic chk_emu();
        i_master.walk(8'b0000_0011, 4);
        i_master.shift({28'h000_0000, tap_port_pkg::IR_EMU}, 4, d);
        `CHK("ir_cap", tap_port_pkg::IR_CAPTURE, d[3:0])
        i_master.walk(8'b0000_0011, 4);
        i_master.shift(32'h0000_0001, tap_port_pkg::EMU_LEN, d);
        i_master.walk(8'b0000_0001, 2);
        wait_halt(1'b1);
    endtask
    // tap reset with no test clock must drop halt and restore the id instruction
    task automatic chk_trst();
        i_master.pulse_trst();
        wait_halt(1'b0);
        i_master.walk(8'b0000_0010, 4);
        i_master.shift(32'hffff_ffff, 32, d);
        `CHK("id_trst", tap_port_pkg::ID_VALUE, d)
        i_master.walk(8'b0000_0001, 2);
    endtask
    // bypass delays by one bit and captures zero
    task automatic chk_bypass();
        i_master.walk(8'b0000_0011, 4);
        i_master.shift({28'h000_0000, tap_port_pkg::IR_BYPASS}, 4, d);
        i_master.walk(8'b0000_0011, 4);
        i_master.shift(32'h0000_00a5, 8, d);
        `CHK("bypass", 8'h4a, d[7:0])
        i_master.walk(8'b0000_0001, 2);
    endtask
    task automatic chk_scan(input logic m, input logic t, input logic e);
        scan_mode_in <= m;
        i_master.set_tdi(t);
        repeat (6) @(posedge sys_clk);
        `CHK("full_scan", e, fse)
    endtask
    initial
    begin
        chk_reset();
        chk_id();
        chk_emu();
        chk_trst();
        chk_bypass();
        chk_scan(1'b1, 1'b1, 1'b1);
        chk_scan(1'b1, 1'b0, 1'b0);
        chk_scan(1'b0, 1'b1, 1'b0);
        report_and_stop();
    end
endmodule
